/* verilog/pap_host.sv */
`timescale 1ns/1ps
`include "pap_params.svh"
module pap_host import pap_pkg::*; (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    pap_if.host LINK
);

    localparam logic [7:0] PHASE = 8'(`PAP_PHASE_CYC);

    pap_host_state_t q;
    pap_host_state_t d;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        d = q;
        d.bus_sy = {q.bus_sy[1:0], LINK.bus};
        if (q.bus_sy[1] == q.bus_sy[2]) begin
            d.bus_f = q.bus_sy[2];
        end

        // AXI write: address and data are taken together, response follows
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (q.awready) begin
            d.awready = 1'b0;
            d.wready = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `PAP_RESP_OKAY;
            case (S_AXI_AWADDR)
                `PAP_REG_CTRL: begin
                    if (!q.busy && S_AXI_WSTRB[0]) begin
                        d.dir = S_AXI_WDATA[`PAP_CTRL_DIR];
                        d.single = S_AXI_WDATA[`PAP_CTRL_SINGLE];
                        d.wts = S_AXI_WDATA[`PAP_CTRL_WTS];
                    end
                    if (!q.busy && S_AXI_WSTRB[1]) begin
                        d.addr = S_AXI_WDATA[`PAP_CTRL_ADDR_LSB +: 5];
                    end
                    if (!q.busy && S_AXI_WSTRB[0] && S_AXI_WDATA[`PAP_CTRL_GO]) begin
                        d.busy = 1'b1;
                        d.done = 1'b0;
                        d.st = PAP_ST_SETUP;
                        d.cnt = PHASE - 8'h01;
                    end
                end
                `PAP_REG_WDATA: begin
                    if (S_AXI_WSTRB[0]) begin
                        d.wdat[7:0] = S_AXI_WDATA[7:0];
                    end
                    if (S_AXI_WSTRB[1]) begin
                        d.wdat[15:8] = S_AXI_WDATA[15:8];
                    end
                end
                `PAP_REG_RDATA, `PAP_REG_STATUS: begin
                end
                default: begin
                    d.bresp = `PAP_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid) begin
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // AXI read
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
        end
        if (q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = `PAP_RESP_OKAY;
            case (S_AXI_ARADDR)
                `PAP_REG_CTRL: d.rdata = {19'h0, q.addr, 4'h0, q.wts, q.single, q.dir, 1'b0};
                `PAP_REG_WDATA: d.rdata = {16'h0, q.wdat};
                `PAP_REG_RDATA: d.rdata = {16'h0, q.rdat};
                `PAP_REG_STATUS: d.rdata = {30'h0, q.done, q.busy};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = `PAP_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_ARVALID && !q.rvalid) begin
            d.arready = 1'b1;
        end

        // Link sequencer; each phase lasts PHASE cycles, long enough for the
        // device's three-stage synchronisers on every pin
        if (q.st != PAP_ST_IDLE) begin
            d.cnt = q.cnt - 8'h01;
        end
        case (q.st)
            PAP_ST_IDLE: begin
                d.ce_n = 1'b1;
                d.rd_n = !q.single;
                d.wr_n = 1'b1;
                d.loe = 1'b0;
            end
            PAP_ST_SETUP: begin
                d.ladr = q.addr;
                d.ldat = q.wdat;
                d.loe = q.dir;
                d.rd_n = !q.single;
                d.wr_n = q.single ? !q.dir : 1'b1;
                if (q.cnt == 8'h00) begin
                    d.ce_n = 1'b0;
                    d.st = PAP_ST_ENABLE;
                    d.cnt = PHASE - 8'h01;
                end
            end
            PAP_ST_ENABLE: begin
                if (q.cnt == 8'h00) begin
                    if (!q.single) begin
                        d.wr_n = !q.dir;
                        d.rd_n = q.dir;
                    end
                    d.st = PAP_ST_STROBE;
                    d.cnt = PHASE - 8'h01;
                end
            end
            PAP_ST_STROBE: begin
                // Data held unchanged for the whole pulse
                if (q.cnt == 8'h00) begin
                    if (!q.dir) begin
                        d.rdat = q.bus_f;
                    end
                    if (q.single) begin
                        d.ce_n = 1'b1;
                    end else begin
                        d.wr_n = 1'b1;
                        d.rd_n = 1'b1;
                    end
                    d.st = PAP_ST_RELEASE;
                    d.cnt = PHASE - 8'h01;
                end
            end
            PAP_ST_RELEASE: begin
                if (q.cnt == 8'h00) begin
                    d.ce_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.st = PAP_ST_END;
                    d.cnt = PHASE - 8'h01;
                end
            end
            PAP_ST_END: begin
                d.loe = 1'b0;
                d.rd_n = !q.single;
                if (q.cnt == 8'h00) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.st = PAP_ST_IDLE;
                end
            end
            default: begin
                d.st = PAP_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.st <= PAP_ST_IDLE;
            q.ce_n <= 1'b1;
            q.rd_n <= 1'b1;
            q.wr_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY = q.wready;
    assign S_AXI_BVALID = q.bvalid;
    assign S_AXI_BRESP = q.bresp;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RVALID = q.rvalid;
    assign S_AXI_RRESP = q.rresp;
    assign S_AXI_RDATA = q.rdata;
    assign LINK.ce_n = q.ce_n;
    assign LINK.rd_n = q.rd_n;
    assign LINK.wr_n = q.wr_n;
    assign LINK.wts = q.wts;
    assign LINK.adr = q.ladr;
    assign LINK.host_dout = q.ldat;
    assign LINK.host_oe = q.loe;

endmodule : pap_host

/* verilog/pap_params.svh */
`ifndef PAP_PARAMS_SVH
`define PAP_PARAMS_SVH

// Register space of the device
`define PAP_GLOBAL_SPAN 16
`define PAP_PAGE_COUNT 88
`define PAP_PAGE_REGS 16
`define PAP_MEM_WORDS (`PAP_PAGE_COUNT * `PAP_PAGE_REGS)
`define PAP_ADDR_PWRDN 4'h0
`define PAP_ADDR_SYNC 4'h1
`define PAP_ADDR_PAGE 4'h2
`define PAP_PWRDN_BITS 6
`define PAP_SYNC_SEL_BITS 3
`define PAP_PAGE_BITS 7
`define PAP_GLOB_RESET 16'h0000
`define PAP_IDLE_BUS 16'hffff

// Host link timing
`define PAP_CLK_NS 10
`define PAP_PHASE_NS 160
`define PAP_PHASE_CYC ((`PAP_PHASE_NS + `PAP_CLK_NS - 1) / `PAP_CLK_NS)

// Host command registers (AXI4-Lite byte offsets)
`define PAP_REG_CTRL 4'h0
`define PAP_REG_WDATA 4'h4
`define PAP_REG_RDATA 4'h8
`define PAP_REG_STATUS 4'hc
`define PAP_CTRL_GO 0
`define PAP_CTRL_DIR 1
`define PAP_CTRL_SINGLE 2
`define PAP_CTRL_WTS 3
`define PAP_CTRL_ADDR_LSB 8
`define PAP_STAT_BUSY 0
`define PAP_STAT_DONE 1
`define PAP_RESP_OKAY 2'h0
`define PAP_RESP_SLVERR 2'h2

`endif

/* verilog/pap_pkg.sv */
package pap_pkg;
`include "pap_params.svh"

    typedef enum logic [2:0] {
        PAP_ST_IDLE = 3'h0,
        PAP_ST_SETUP = 3'h1,
        PAP_ST_ENABLE = 3'h2,
        PAP_ST_STROBE = 3'h3,
        PAP_ST_RELEASE = 3'h4,
        PAP_ST_END = 3'h5
    } pap_host_st_t;

    typedef struct packed {
        logic [2:0] ce_sy;
        logic [2:0] wr_sy;
        logic [2:0] rd_sy;
        logic [2:0] wts_sy;
        logic [2:0][4:0] adr_sy;
        logic [2:0][15:0] dat_sy;
        logic ce_f;
        logic wr_f;
        logic rd_f;
        logic wts_f;
        logic [4:0] adr_f;
        logic [15:0] dat_f;
        logic wr_act;
        logic [4:0] wa;
        logic [15:0] wd;
        logic [15:0][15:0] glob;
        logic [15:0] dout;
        logic oe;
        logic stb;
        logic [6:0] spage;
        logic [4:0] sadr;
        logic [15:0] sdat;
    } pap_dev_state_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic dir;
        logic single;
        logic wts;
        logic [4:0] addr;
        logic [15:0] wdat;
        logic [15:0] rdat;
        logic busy;
        logic done;
        pap_host_st_t st;
        logic [7:0] cnt;
        logic [2:0][15:0] bus_sy;
        logic [15:0] bus_f;
        logic ce_n;
        logic rd_n;
        logic wr_n;
        logic [4:0] ladr;
        logic [15:0] ldat;
        logic loe;
    } pap_host_state_t;

endpackage : pap_pkg

/* verilog/pap_if.sv */
`timescale 1ns/1ps
interface pap_if;
    logic ce_n;
    logic rd_n;
    logic wr_n;
    logic wts;
    logic [4:0] adr;
    logic [15:0] host_dout;
    logic host_oe;
    logic [15:0] dev_dout;
    logic dev_oe;
    logic [15:0] bus;

    // Shared data bus; an undriven bus reads as pulled up
    assign bus = host_oe ? host_dout : (dev_oe ? dev_dout : 16'hffff);

    modport host (
        output ce_n, rd_n, wr_n, wts, adr, host_dout, host_oe,
        input bus
    );

    modport dev (
        input ce_n, rd_n, wr_n, wts, adr, bus,
        output dev_dout, dev_oe
    );
endinterface : pap_if

/* verilog/pap_device.sv */
`timescale 1ns/1ps
`include "pap_params.svh"
module pap_device import pap_pkg::*; (
    input wire logic MCLK,
    input wire logic RESETN,
    pap_if.dev LINK,
    output logic [`PAP_PWRDN_BITS-1:0] BLOCK_RESET,
    output logic [`PAP_SYNC_SEL_BITS-1:0] SYNC_OUT_SEL,
    output logic CFG_WR_STB,
    output logic [`PAP_PAGE_BITS-1:0] CFG_WR_PAGE,
    output logic [4:0] CFG_WR_ADDR,
    output logic [15:0] CFG_WR_DATA
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and paged memory

    pap_dev_state_t q;
    pap_dev_state_t d;

    // Paged registers are configuration only and carry no reset
    logic [15:0] page_mem [0:`PAP_MEM_WORDS-1];

    logic wr_now;
    logic rd_now;
    logic commit;
    logic [4:0] c_adr;
    logic [15:0] c_dat;
    logic page_ok;
    logic [`PAP_PAGE_BITS-1:0] page;
    logic mem_we;
    logic [10:0] mem_widx;
    logic [10:0] mem_ridx;
    logic [15:0] rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        d = q;

        // Three-stage synchronisers; a change counts once stages two and three agree
        d.ce_sy = {q.ce_sy[1:0], LINK.ce_n};
        d.wr_sy = {q.wr_sy[1:0], LINK.wr_n};
        d.rd_sy = {q.rd_sy[1:0], LINK.rd_n};
        d.wts_sy = {q.wts_sy[1:0], LINK.wts};
        d.adr_sy = {q.adr_sy[1:0], LINK.adr};
        d.dat_sy = {q.dat_sy[1:0], LINK.bus};
        if (q.ce_sy[1] == q.ce_sy[2]) begin
            d.ce_f = q.ce_sy[2];
        end
        if (q.wr_sy[1] == q.wr_sy[2]) begin
            d.wr_f = q.wr_sy[2];
        end
        if (q.rd_sy[1] == q.rd_sy[2]) begin
            d.rd_f = q.rd_sy[2];
        end
        if (q.wts_sy[1] == q.wts_sy[2]) begin
            d.wts_f = q.wts_sy[2];
        end
        if (q.adr_sy[1] == q.adr_sy[2]) begin
            d.adr_f = q.adr_sy[2];
        end
        if (q.dat_sy[1] == q.dat_sy[2]) begin
            d.dat_f = q.dat_sy[2];
        end

        // A grounded read strobe leaves only the write strobe to tell direction,
        // so one pair of terms serves dual and single strobe alike
        wr_now = !q.ce_f && !q.wr_f;
        rd_now = !q.ce_f && !q.rd_f && q.wr_f;

        page = q.glob[`PAP_ADDR_PAGE][`PAP_PAGE_BITS-1:0];
        page_ok = (q.glob[`PAP_ADDR_PAGE] < 16'(`PAP_PAGE_COUNT));

        // Write capture
        d.wr_act = wr_now;
        if (wr_now) begin
            d.wa = q.adr_f;
            d.wd = q.dat_f;
        end
        commit = 1'b0;
        c_adr = q.adr_f;
        c_dat = q.dat_f;
        if (q.wts_f) begin
            // Transparent: every cycle of the pulse writes, transients included
            commit = wr_now;
        end else if (q.wr_act && !wr_now) begin
            // End of the low period: the write strobe rise in dual strobe,
            // the select rise in single strobe
            commit = 1'b1;
            c_adr = q.wa;
            c_dat = q.wd;
        end

        mem_we = 1'b0;
        mem_widx = {page, c_adr[3:0]};
        if (commit) begin
            if (!c_adr[4]) begin
                d.glob[c_adr[3:0]] = c_dat;
            end else if (page_ok) begin
                mem_we = 1'b1;
            end
        end

        // Write notice toward the processing logic, already in the core domain
        d.stb = commit && (!c_adr[4] || page_ok);
        d.spage = c_adr[4] ? page : 7'h00;
        d.sadr = c_adr;
        d.sdat = c_dat;

        // Read path
        mem_ridx = {page, q.adr_f[3:0]};
        if (!q.adr_f[4]) begin
            rdata = q.glob[q.adr_f[3:0]];
        end else if (page_ok) begin
            rdata = page_mem[mem_ridx];
        end else begin
            rdata = 16'h0000;
        end
        d.dout = rdata;
        d.oe = rd_now;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            q.ce_sy <= 3'h7;
            q.wr_sy <= 3'h7;
            q.rd_sy <= 3'h7;
            q.wts_sy <= 3'h0;
            q.adr_sy <= '0;
            q.dat_sy <= '0;
            q.ce_f <= 1'b1;
            q.wr_f <= 1'b1;
            q.rd_f <= 1'b1;
            q.wts_f <= 1'b0;
            q.adr_f <= 5'h00;
            q.dat_f <= 16'h0000;
            q.wr_act <= 1'b0;
            q.wa <= 5'h00;
            q.wd <= 16'h0000;
            q.glob <= {`PAP_GLOBAL_SPAN{`PAP_GLOB_RESET}};
            q.dout <= 16'h0000;
            q.oe <= 1'b0;
            q.stb <= 1'b0;
            q.spage <= 7'h00;
            q.sadr <= 5'h00;
            q.sdat <= 16'h0000;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (mem_we) begin
            page_mem[mem_widx] <= c_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign LINK.dev_dout = q.dout;
    assign LINK.dev_oe = q.oe;

    // Power-down bits hold the blocks in reset; the stored settings stay intact
    // and the channels need a fresh sync once released
    assign BLOCK_RESET = q.glob[`PAP_ADDR_PWRDN][`PAP_PWRDN_BITS-1:0];
    assign SYNC_OUT_SEL = q.glob[`PAP_ADDR_SYNC][`PAP_SYNC_SEL_BITS-1:0];
    assign CFG_WR_STB = q.stb;
    assign CFG_WR_PAGE = q.spage;
    assign CFG_WR_ADDR = q.sadr;
    assign CFG_WR_DATA = q.sdat;

endmodule : pap_device

/* testbench/pap_checker.sv */
`timescale 1ns/1ps
module pap_checker (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic ce_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic wts,
    input wire logic [4:0] adr,
    input wire logic [15:0] host_dout,
    input wire logic host_oe,
    input wire logic [15:0] dev_dout,
    input wire logic dev_oe,
    input wire logic [15:0] bus
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////
    // Eight cycles covers the device's pin synchroniser delay
    a_sel_high_quiet: assert property (ce_n [*8] |-> !dev_oe)
        else $error("device drives data while deselected");
    a_rd_high_quiet: assert property (rd_n [*8] |-> !dev_oe)
        else $error("device drives data with read strobe high");
    a_wr_low_quiet: assert property (!wr_n [*8] |-> !dev_oe)
        else $error("device drives data during a write");
    a_no_contend: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the data bus");
    a_read_cause: assert property ($rose(dev_oe) |-> !ce_n && !rd_n && !$past(ce_n, 3) && !$past(rd_n, 3))
        else $error("read drive without select and read strobe");
    a_single_dir: assert property ($rose(dev_oe) |-> wr_n && $past(wr_n, 3))
        else $error("read drive while write strobe low");
    a_write_order: assert property ($fell(wr_n) && rd_n |-> !ce_n && host_oe && !$past(ce_n, 2))
        else $error("dual write strobe out of order");
    a_setup_stable: assert property ($fell(ce_n) |-> $stable(adr) && $stable(wr_n) && $stable(rd_n))
        else $error("address or strobes moved at select");
    a_read_end: assert property ($rose(rd_n) && !ce_n |-> ##[1:40] ce_n)
        else $error("select not released after read");
    a_latch_hold: assert property (!ce_n && !wr_n && !$past(ce_n) && !$past(wr_n) |-> $stable(host_dout) && $stable(adr))
        else $error("data or address moved during write pulse");

    c_dev_read: cover property ($rose(dev_oe));
    c_dual_write: cover property ($rose(wr_n) && !ce_n && rd_n);
    c_single_write: cover property ($rose(ce_n) && !wr_n && !rd_n);
    c_latch_write: cover property (wts && !ce_n && !wr_n);
endmodule : pap_checker

/* testbench/paged_async_control_port_tb.sv */
`timescale 1ns/1ps
`include "pap_params.svh"
module paged_async_control_port_tb import pap_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [5:0] block_reset;
    logic [2:0] sync_sel;
    logic cfg_stb;
    logic [6:0] cfg_page, stb_page;
    logic [4:0] cfg_addr, stb_addr;
    logic [15:0] cfg_data, stb_data;
    int fails = 0, tests_run = 0, stb_n = 0;

    pap_if u_pap_if ();
    pap_device u_pap_device (.MCLK(mclk), .RESETN(resetn), .LINK(u_pap_if.dev), .BLOCK_RESET(block_reset),
        .SYNC_OUT_SEL(sync_sel), .CFG_WR_STB(cfg_stb), .CFG_WR_PAGE(cfg_page), .CFG_WR_ADDR(cfg_addr),
        .CFG_WR_DATA(cfg_data));
    pap_host u_pap_host (.MCLK(mclk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK(u_pap_if.host));
    pap_checker u_pap_checker (.MCLK(mclk), .RESETN(resetn), .ce_n(u_pap_if.ce_n), .rd_n(u_pap_if.rd_n),
        .wr_n(u_pap_if.wr_n), .wts(u_pap_if.wts), .adr(u_pap_if.adr), .host_dout(u_pap_if.host_dout),
        .host_oe(u_pap_if.host_oe), .dev_dout(u_pap_if.dev_dout), .dev_oe(u_pap_if.dev_oe),
        .bus(u_pap_if.bus));

    always #5 mclk = ~mclk;

    // Record every committed configuration word as the core sees it
    always @(posedge mclk) begin
        if (cfg_stb === 1'b1) begin
            stb_n++;
            stb_page = cfg_page;
            stb_addr = cfg_addr;
            stb_data = cfg_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // One link transfer ordered through the host's command registers
    task automatic link_op(input logic wr, input logic sgl, input logic lat, input logic [4:0] a,
                           input logic [15:0] d, output logic [15:0] q);
        logic [31:0] v;
        logic [1:0] r;
        int n;
        stb_n = 0;
        n = 0;
        axi_wr(`PAP_REG_WDATA, {16'h0000, d}, r);
        axi_wr(`PAP_REG_CTRL, {19'h00000, a, 4'h0, lat, sgl, wr, 1'b1}, r);
        check(r === `PAP_RESP_OKAY, "control write response");
        do begin
            axi_rd(`PAP_REG_STATUS, v, r);
            n++;
        end while (v[`PAP_STAT_DONE] !== 1'b1 && n < 100);
        check(n < 100, "link transfer never finished");
        axi_rd(`PAP_REG_RDATA, v, r);
        q = v[15:0];
    endtask : link_op

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] q;
        check(block_reset === 6'h00 && sync_sel === 3'h0, "outputs after reset");
        link_op(1'b0, 1'b0, 1'b0, 5'h02, 16'h0000, q);
        check(q === 16'h0000, "page register after reset");
    endtask : t_reset

    // Every pairing of strobe style and write timing, each read back
    task automatic t_modes();
        logic [15:0] q;
        for (int m = 0; m < 4; m++) begin
            link_op(1'b1, m[0], m[1], 5'h04 + 5'(m), 16'h1100 + 16'(m), q);
            check(m[1] ? stb_n > 1 : stb_n == 1, "commit count");
            check(stb_data === 16'h1100 + 16'(m) && stb_addr === 5'h04 + 5'(m) && stb_page === 7'h00,
                  "committed word");
            link_op(1'b0, m[0], 1'b0, 5'h04 + 5'(m), 16'h0000, q);
            check(q === 16'h1100 + 16'(m), "read back");
        end
    endtask : t_modes

    task automatic t_power();
        logic [15:0] q;
        link_op(1'b1, 1'b0, 1'b0, 5'h00, 16'h002a, q);
        link_op(1'b1, 1'b0, 1'b0, 5'h01, 16'h0005, q);
        check(block_reset === 6'h2a, "block resets held");
        check(sync_sel === 3'h5, "sync output select");
        link_op(1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, q);
        check(q === 16'h002a, "power-down word kept");
        link_op(1'b1, 1'b0, 1'b0, 5'h00, 16'h0000, q);
        check(block_reset === 6'h00, "blocks released");
        // Released channels get a fresh sync setup before they are used again
        link_op(1'b1, 1'b0, 1'b0, 5'h01, 16'h0004, q);
        check(sync_sel === 3'h4 && block_reset === 6'h00, "resync after power-up");
    endtask : t_power

    // Last legal page against a low one, then a page past the end
    task automatic t_paged();
        logic [15:0] q;
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd87, q);
        link_op(1'b1, 1'b0, 1'b0, 5'h13, 16'hbeef, q);
        check(stb_page === 7'd87 && stb_addr === 5'h13, "paged commit");
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd3, q);
        link_op(1'b1, 1'b0, 1'b0, 5'h13, 16'h1234, q);
        link_op(1'b1, 1'b0, 1'b0, 5'h03, 16'h0303, q);
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd87, q);
        link_op(1'b0, 1'b0, 1'b0, 5'h13, 16'h0000, q);
        check(q === 16'hbeef, "page 87 kept its word");
        link_op(1'b0, 1'b0, 1'b0, 5'h03, 16'h0000, q);
        check(q === 16'h0303, "global word seen from any page");
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd3, q);
        link_op(1'b0, 1'b1, 1'b0, 5'h13, 16'h0000, q);
        check(q === 16'h1234, "page 3 word");
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd88, q);
        link_op(1'b0, 1'b0, 1'b0, 5'h13, 16'h0000, q);
        check(q === 16'h0000, "page past the end reads zero");
        link_op(1'b1, 1'b0, 1'b0, 5'h02, 16'd0, q);
    endtask : t_paged

    task automatic t_axi();
        logic [31:0] v;
        logic [1:0] r;
        axi_rd(4'h6, v, r);
        check(r === `PAP_RESP_SLVERR && v === 32'h0, "unmapped read");
        axi_wr(4'h6, 32'h0000_00ff, r);
        check(r === `PAP_RESP_SLVERR, "unmapped write");
        axi_rd(`PAP_REG_CTRL, v, r);
        check(r === `PAP_RESP_OKAY && v[`PAP_CTRL_GO] === 1'b0, "start bit self-clears");
        // A control write while a transfer runs is ignored
        axi_wr(`PAP_REG_CTRL, 32'h0000_0401, r);
        axi_wr(`PAP_REG_CTRL, 32'h0000_1f03, r);
        check(r === `PAP_RESP_OKAY, "busy write response");
        axi_rd(`PAP_REG_STATUS, v, r);
        check(v[`PAP_STAT_BUSY] === 1'b1 && v[`PAP_STAT_DONE] === 1'b0, "busy during transfer");
        axi_rd(`PAP_REG_CTRL, v, r);
        check(v[12:8] === 5'h04 && v[`PAP_CTRL_DIR] === 1'b0, "control held while busy");
        repeat (120) @(posedge mclk);
        axi_rd(`PAP_REG_STATUS, v, r);
        check(v[1:0] === 2'b10, "transfer finished");
        axi_rd(`PAP_REG_RDATA, v, r);
        check(v[15:0] === 16'h1100, "read ordered before the ignored write");
    endtask : t_axi

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        // Let the device's pin synchronisers fill before any traffic
        repeat (6) @(posedge mclk);
        t_reset();
        t_modes();
        t_power();
        t_paged();
        t_axi();
        final_report();
    end

    initial begin
        #400000;
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : paged_async_control_port_tb
